// ### logic/temp_conv_pkg.sv
// Constants and types shared by the temperature conversion sequencer
package temp_conv_pkg;
  localparam int unsigned CLK_HZ           = 20000000;
  // Worst-case conversion duration at the 9-bit setting, in ms
  localparam int unsigned CONV_9BIT_MS     = 150;
  localparam longint unsigned CONV_9BIT_CYC =
    (longint'(CONV_9BIT_MS) * longint'(CLK_HZ)) / 64'd1000;
  localparam int unsigned RES_W            = 2;
  localparam int unsigned RESULT_W         = 16;
  localparam int unsigned RAW_W            = 12;
  localparam int unsigned CNT_W            = 26;
  localparam logic [RES_W-1:0]    RES_RESET    = 2'h0;
  localparam logic                MODE_RESET   = 1'h0;
  localparam logic                LOWPWR_RESET = 1'h0;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 16'h0000;
  localparam int unsigned DATA_LSB_12BIT   = 4;
  localparam int unsigned RES_STEPS        = 3;
  typedef enum logic [1:0] {
    RES_9BIT,
    RES_10BIT,
    RES_11BIT,
    RES_12BIT
  } res_sel_t;
  typedef enum logic [1:0] {
    ST_CONVERT,
    ST_STANDBY
  } seq_state_t;
endpackage

// ### logic/conv_timer.sv
// Conversion duration timer scaled by resolution
`timescale 1ns/10ps
`default_nettype none
module conv_timer #(
  parameter longint unsigned BASE_CYCLES = temp_conv_pkg::CONV_9BIT_CYC
) (
  input  wire logic                           clk,
  input  wire logic                           rst_b,
  input  wire logic                           start,
  input  wire logic [temp_conv_pkg::RES_W-1:0] res,
  output logic                                done
);
  import temp_conv_pkg::*;
  initial begin
    if (BASE_CYCLES < 1 || (BASE_CYCLES << RES_STEPS) >= (64'd1 << CNT_W))
      $error("conv_timer: BASE_CYCLES out of range");
  end
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic             next_done;
  // [R1] [R15] Span doubles per bit
  function automatic logic [CNT_W-1:0] span(input logic [RES_W-1:0] r);
    logic [CNT_W-1:0] base;
    base = BASE_CYCLES[CNT_W-1:0];
    span = base << r;
  endfunction
  always_comb begin
    next_count = count;
    next_done  = 1'b0;
    if (start) begin
      next_count = span(res) - CNT_W'(1);
    end else if (count != '0) begin
      next_count = count - CNT_W'(1);
      next_done  = (count == CNT_W'(1));
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
      done  <= 1'b0;
    end else begin
      count <= next_count;
      done  <= next_done;
    end
  end
endmodule
`default_nettype wire

// ### logic/temp_conversion_result_shutdown.sv
// Background temperature conversion sequencer and result register
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// [R1] Each extra resolution bit doubles conversion time
// [R2] Conversions start right after reset, unprompted
// [R3] Resolution 9 to 12 bits, 9 after reset
// [R4] Resolution comes from two select bits
// [R5] Result stored as 16-bit two's complement
// [R6] Bit 15 sign, bits 14-4 weighted data
// [R7] 12-bit encoding matches reference points
// [R8] Reads never disturb conversion in progress
// [R9] Result bits 3 to 0 read zero
// [R10] Unused low bits below resolution read zero
// [R11] Shutdown finishes current conversion, then standby
// [R12] Shutdown clears alarm only in interrupt mode
// [R13] Register access works during shutdown
// [R14] Clearing shutdown resumes measuring
// [R15] Select 00..11 maps 9..12 bits, 150..1200ms
// [R16] Configuration bits default at every reset
// [R17] Next conversion starts when previous completes
// [R18] Result word updates atomically
module temp_conversion_result_shutdown #(
  parameter longint unsigned CONV_BASE_CYCLES =
    temp_conv_pkg::CONV_9BIT_CYC
) (
  input  wire logic                                CLK,
  input  wire logic                                RST_B,
  input  wire logic                                CFG_WRITE,
  input  wire logic                                RES_SELECT_LOW,
  input  wire logic                                RES_SELECT_HIGH,
  input  wire logic                                LOW_POWER_REQUEST,
  input  wire logic                                ALARM_BEHAVIOUR_SELECT,
  input  wire logic [temp_conv_pkg::RAW_W-1:0]     ADC_SAMPLE,
  input  wire logic                                ALARM_IN,
  output logic [temp_conv_pkg::RESULT_W-1:0]       TEMPERATURE_RESULT,
  output logic [temp_conv_pkg::RES_W-1:0]          RES_ACTIVE,
  output logic                                     LOW_POWER_STATE,
  output logic                                     ALARM_MODE,
  output logic                                     CONV_DONE,
  output logic                                     ALARM_OUT
);
  import temp_conv_pkg::*;

  initial begin
    if (CONV_BASE_CYCLES < 1)
      $error("CONV_BASE_CYCLES must be at least one cycle");
  end

  // Configuration state
  logic [RES_W-1:0] res_cfg;
  logic [RES_W-1:0] next_res_cfg;
  logic             mode_cfg;
  logic             next_mode_cfg;
  logic             lowpwr_cfg;
  logic             next_lowpwr_cfg;

  // Sequencer state
  seq_state_t          state;
  seq_state_t          next_state;
  logic                start;
  logic                next_start;
  logic [RES_W-1:0]    conv_res;
  logic [RES_W-1:0]    next_conv_res;
  logic                timer_done;
  logic [RESULT_W-1:0] result;
  logic [RESULT_W-1:0] next_result;
  logic                done_pulse;
  logic                next_done_pulse;
  logic                alarm;
  logic                next_alarm;
  // Standby flag kept in a flop so the output is glitch free
  logic                lowpwr_state;
  logic                next_lowpwr_state;

  // Sample and alarm come from the analog front end in another domain
  logic [RAW_W-1:0] sample_meta;
  logic [RAW_W-1:0] sample_sync;
  logic             alarm_meta;
  logic             alarm_sync;

  // [R6] [R7] Sign and weights placed
  // Trims a 12-bit reading to the resolution and places it in bits 15:4
  function automatic logic [RESULT_W-1:0] format_result(
    input logic [RAW_W-1:0] raw,
    input logic [RES_W-1:0] r
  );
    logic [RAW_W-1:0] mask;
    mask = {RAW_W{1'b1}} << (RES_STEPS - int'(r));
    format_result = {raw & mask, {DATA_LSB_12BIT{1'b0}}};
  endfunction

  conv_timer #(
    .BASE_CYCLES (CONV_BASE_CYCLES)
  ) u_timer (
    .clk   (CLK),
    .rst_b (RST_B),
    .start (start),
    .res   (conv_res),
    .done  (timer_done)
  );

  // Configuration write path
  always_comb begin
    next_res_cfg    = res_cfg;
    next_mode_cfg   = mode_cfg;
    next_lowpwr_cfg = lowpwr_cfg;
    // [R13] Writes always accepted
    if (CFG_WRITE) begin
      // [R4] Select bits stored
      next_res_cfg    = {RES_SELECT_HIGH, RES_SELECT_LOW};
      next_mode_cfg   = ALARM_BEHAVIOUR_SELECT;
      next_lowpwr_cfg = LOW_POWER_REQUEST;
    end
  end

  // [R16] [R3] Defaults at reset
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      res_cfg    <= RES_RESET;
      mode_cfg   <= MODE_RESET;
      lowpwr_cfg <= LOWPWR_RESET;
    end else begin
      res_cfg    <= next_res_cfg;
      mode_cfg   <= next_mode_cfg;
      lowpwr_cfg <= next_lowpwr_cfg;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sample_meta <= '0;
      sample_sync <= '0;
      alarm_meta  <= 1'b0;
      alarm_sync  <= 1'b0;
    end else begin
      sample_meta <= ADC_SAMPLE;
      sample_sync <= sample_meta;
      alarm_meta  <= ALARM_IN;
      alarm_sync  <= alarm_meta;
    end
  end

  // Sequencer
  always_comb begin
    next_state      = state;
    next_start      = 1'b0;
    next_conv_res   = conv_res;
    next_result     = result;
    next_done_pulse = 1'b0;
    next_alarm      = alarm_sync;
    case (state)
      ST_CONVERT: begin
        if (timer_done) begin
          // [R5] Store formatted result; [R9] low nibble zero
          // [R10] Bits below resolution cleared
          // [R18] Whole word loaded in one edge
          next_result     = format_result(sample_sync, conv_res);
          next_done_pulse = 1'b1;
          // [R11] Standby only after completion
          if (lowpwr_cfg) begin
            next_state = ST_STANDBY;
            // [R12] Interrupt mode alarm cleared
            if (mode_cfg)
              next_alarm = 1'b0;
          end else begin
            // [R17] Back-to-back conversions
            next_start    = 1'b1;
            next_conv_res = res_cfg;
          end
        end
      end
      ST_STANDBY: begin
        // Alarm held low in interrupt mode while standing by
        if (mode_cfg)
          next_alarm = 1'b0;
        // [R14] Resume on clear
        if (!lowpwr_cfg) begin
          next_state    = ST_CONVERT;
          next_start    = 1'b1;
          next_conv_res = res_cfg;
        end
      end
      default: begin
        next_state = ST_CONVERT;
        next_start = 1'b1;
      end
    endcase
    next_lowpwr_state = (next_state == ST_STANDBY);
  end

  // [R2] First conversion launched by reset
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state      <= ST_CONVERT;
      start      <= 1'b1;
      conv_res   <= RES_RESET;
      result     <= RESULT_RESET;
      done_pulse <= 1'b0;
      alarm      <= 1'b0;
      lowpwr_state <= 1'b0;
    end else begin
      lowpwr_state <= next_lowpwr_state;
      state      <= next_state;
      start      <= next_start;
      conv_res   <= next_conv_res;
      result     <= next_result;
      done_pulse <= next_done_pulse;
      alarm      <= next_alarm;
    end
  end

  // [R8] Result read straight from register, no side effects
  assign TEMPERATURE_RESULT = result;
  assign RES_ACTIVE         = res_cfg;
  assign LOW_POWER_STATE    = lowpwr_state;
  assign ALARM_MODE         = mode_cfg;
  assign CONV_DONE          = done_pulse;
  assign ALARM_OUT          = alarm;
endmodule
`default_nettype wire

// ### verif/temp_conv_assertions.sv
// Port-level checker for the conversion sequencer
`timescale 1ns/10ps
`default_nettype none
module temp_conv_assertions #(
  parameter longint unsigned CONV_BASE_CYCLES = 20
) (
  input wire logic                                CLK,
  input wire logic                                RST_B,
  input wire logic                                ALARM_IN,
  input wire logic [temp_conv_pkg::RESULT_W-1:0] TEMPERATURE_RESULT,
  input wire logic [temp_conv_pkg::RES_W-1:0]    RES_ACTIVE,
  input wire logic                                LOW_POWER_STATE,
  input wire logic                                ALARM_MODE,
  input wire logic                                CONV_DONE,
  input wire logic                                ALARM_OUT
);
  import temp_conv_pkg::*;
  // Quiet span before the next completion, a few cycles of slack
  localparam int Q9  = int'(CONV_BASE_CYCLES) - 3;
  localparam int Q12 = 8 * int'(CONV_BASE_CYCLES) - 3;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  property p_low_zero;
    TEMPERATURE_RESULT[3:0] == 4'h0;
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("low bits");
  property p_mask9;
    CONV_DONE && RES_ACTIVE == 2'h0 |-> TEMPERATURE_RESULT[6:4] == 3'h0;
  endproperty
  a_mask9: assert property (p_mask9) else $error("mask");
  property p_atomic;
    !CONV_DONE |-> $stable(TEMPERATURE_RESULT);
  endproperty
  a_atomic: assert property (p_atomic) else $error("moved");
  property p_conv9;
    CONV_DONE ##1 (!LOW_POWER_STATE && RES_ACTIVE == 2'h0)
      |-> (!CONV_DONE throughout ##Q9 1'b1) ##[0:6] CONV_DONE;
  endproperty
  a_conv9: assert property (p_conv9) else $error("span");
  property p_conv12;
    CONV_DONE ##1 (!LOW_POWER_STATE && RES_ACTIVE == 2'h3)
      |-> (!CONV_DONE throughout ##Q12 1'b1) ##[0:6] CONV_DONE;
  endproperty
  a_conv12: assert property (p_conv12) else $error("span");
  property p_entry;
    $rose(LOW_POWER_STATE) |-> CONV_DONE;
  endproperty
  a_entry: assert property (p_entry) else $error("entry");
  property p_int_clr;
    LOW_POWER_STATE && ALARM_MODE && $past(LOW_POWER_STATE && ALARM_MODE)
      |-> !ALARM_OUT;
  endproperty
  a_int_clr: assert property (p_int_clr) else $error("alarm");
  property p_cmp;
    (RST_B && !ALARM_MODE)[*4] |-> ALARM_OUT == $past(ALARM_IN, 3);
  endproperty
  a_cmp: assert property (p_cmp) else $error("alarm");
  c_done12: cover property (CONV_DONE && RES_ACTIVE == 2'h3);
  c_standby: cover property ($rose(LOW_POWER_STATE));
  c_int_sd: cover property (LOW_POWER_STATE && ALARM_MODE);
endmodule
bind temp_conversion_result_shutdown temp_conv_assertions #(
  .CONV_BASE_CYCLES(CONV_BASE_CYCLES)
) chk_i (
  .CLK(CLK), .RST_B(RST_B), .ALARM_IN(ALARM_IN),
  .TEMPERATURE_RESULT(TEMPERATURE_RESULT), .RES_ACTIVE(RES_ACTIVE),
  .LOW_POWER_STATE(LOW_POWER_STATE), .ALARM_MODE(ALARM_MODE),
  .CONV_DONE(CONV_DONE), .ALARM_OUT(ALARM_OUT)
);
`default_nettype wire

// ### verif/host_model.sv
// Host controller model that writes the configuration bits
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input  wire logic clk,
  output logic      cfg_write,
  output logic      res_select_low,
  output logic      res_select_high,
  output logic      low_power_request,
  output logic      alarm_behaviour_select
);
  initial {cfg_write, res_select_low, res_select_high} = 3'h0;
  initial {low_power_request, alarm_behaviour_select} = 2'h0;
  // Writes at any time, clearing shutdown resumes
  task automatic wr(input logic [1:0] r, input logic lp, input logic m);
    @(posedge clk);
    cfg_write <= 1'b1;
    {res_select_high, res_select_low} <= r;
    low_power_request <= lp;
    alarm_behaviour_select <= m;
    @(posedge clk);
    cfg_write <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import temp_conv_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [RAW_W-1:0] smp;
  logic alarm_in = 1'b0;
  logic cfg_write, rlo, rhi, lpr, amsel, done, lps, amode, aout;
  logic [RESULT_W-1:0] result;
  logic [RES_W-1:0] res_act;
  logic [1:0] cr = 2'h0;
  logic [15:0] refs [4] = '{16'h1910, 16'hFF80, 16'hC900, 16'h7D00};
  integer seed = 32'hEE5E224F;
  int num_errors = 0;
  int num_checks = 0;
  always #25 clk = ~clk;
  always @(posedge clk) alarm_in <= 1'($random(seed));
  host_model host (.clk(clk), .cfg_write(cfg_write), .res_select_low(rlo),
    .res_select_high(rhi), .low_power_request(lpr),
    .alarm_behaviour_select(amsel));
  temp_conversion_result_shutdown #(.CONV_BASE_CYCLES(20)) dut (
    .CLK(clk), .RST_B(rst_b), .CFG_WRITE(cfg_write),
    .RES_SELECT_LOW(rlo), .RES_SELECT_HIGH(rhi),
    .LOW_POWER_REQUEST(lpr), .ALARM_BEHAVIOUR_SELECT(amsel),
    .ADC_SAMPLE(smp), .ALARM_IN(alarm_in), .TEMPERATURE_RESULT(result),
    .RES_ACTIVE(res_act), .LOW_POWER_STATE(lps), .ALARM_MODE(amode),
    .CONV_DONE(done), .ALARM_OUT(aout));
  function automatic logic [15:0] expect_word(logic [11:0] s,
                                              logic [1:0] r);
    return {s, 4'h0} & (16'hFFF0 << (2'h3 - r));
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    num_checks++;
    if (got !== want) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic wdone;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (done !== 1'b1 && n < 400);
    chk(16'(n < 400), 16'h0001);
  endtask
  // Resolution is changed only in standby, so the running one is kept
  task automatic conv(input logic [1:0] r, input logic [11:0] s);
    host.wr(cr, 1'b1, r[0]);
    wdone;
    chk(16'(lps), 16'h0001);
    chk(16'(aout & amode), 16'h0000);
    host.wr(r, 1'b1, r[0]);
    @(posedge clk) smp <= s;
    #1 chk(16'(res_act), 16'(r));
    chk(16'(lps), 16'h0001);
    host.wr(r, 1'b0, 1'b0);
    @(posedge clk);
    #1 chk(16'(lps), 16'h0000);
    wdone;
    chk(result, expect_word(s, r));
    cr = r;
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    smp = 12'($random(seed));
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    #1 chk({12'h000, res_act, lps, amode}, 16'h0000);
    chk(result, 16'h0000);
    wdone;
    chk(result, expect_word(smp, 2'h0));
    for (int i = 0; i < 4; i++) conv(2'(i), 12'($random(seed)));
    for (int i = 0; i < 4; i++) begin
      conv(2'h3, refs[i][15:4]);
      chk(result, refs[i]);
    end
    @(posedge clk) rst_b <= 1'b0;
    #1 chk({12'h000, res_act, lps, amode}, 16'h0000);
    complete_run;
  end
  initial begin
    #500000;
    num_errors++;
    complete_run;
  end
endmodule
`default_nettype wire
